// *** core/bridge_far_side_control.sv ***
// Far-side mode, guard, reset reaction and chip reset control for one bridge side.
`timescale 1ns/1ps
module bridge_far_side_control
  import bridge_pkg::*;
#(
  parameter bit IS_INTERNAL = 1'b1
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire cfg_req_t   cfg_req,
  output cfg_rsp_t        cfg_rsp,
  output logic            cap_write_block,
  output logic            cap_read_zero,
  input  wire reset_evt_t int_reset,
  input  wire reset_evt_t far_reset,
  input  wire logic       isolating_bridge,
  input  wire logic       bridge_port_reset_pin_n,
  input  wire logic [1:0] peer_mode,
  input  wire logic       peer_force_not_ready,
  output logic            force_peer_not_ready,
  output logic [1:0]      far_side_mode,
  input  wire logic       far_tlp_valid,
  input  wire logic       far_tlp_is_cfg,
  output logic            far_tlp_accept,
  output logic            far_tlp_crs,
  output logic            far_tlp_discard,
  output logic            far_credit_return,
  output logic            near_to_far_allow,
  output logic            chip_fund_reset
);
  logic [1:0] mode_q;
  logic       guard_q;
  logic       react_en_q;
  logic       react_sel_q;
  logic       propagate_q;
  logic       fund_seen_q;
  logic       chip_rst_q;
  logic       yield;
  logic       in_cap;
  logic       guarded;
  logic       wr_ctl;
  logic       wr_sts;
  logic       far_rst_evt;
  logic       react_self;
  logic       sticky_clr;
  logic [7:0] ctl_view;
  logic [7:0] sts_view;

  // ---------------------------------------------------------------------------
  // Access decode
  // ---------------------------------------------------------------------------
  always_comb begin
    in_cap  = (cfg_req.addr >= CAP_BASE) && (cfg_req.addr < CAP_BASE + CAP_LENGTH);
    guarded = cfg_req.valid && cfg_req.from_far && guard_q && in_cap;
    wr_ctl  = cfg_req.valid && cfg_req.write && !guarded && (cfg_req.addr == CTL_OFFSET);
    wr_sts  = cfg_req.valid && cfg_req.write && !guarded && (cfg_req.addr == STS_OFFSET);
    cap_write_block = guarded && cfg_req.write;
    cap_read_zero   = guarded && !cfg_req.write && (cfg_req.addr > CAP_HDR_LAST);
  end

  // ---------------------------------------------------------------------------
  // Reset reaction
  // ---------------------------------------------------------------------------
  // Only the internal side may hold the reaction bits, so the external side never
  // reacts and never forces its peer.
  always_comb begin
    far_rst_evt = far_reset.fund || far_reset.hot;
    react_self  = react_en_q && far_rst_evt && (react_sel_q != REACT_PEER);
    force_peer_not_ready = react_en_q && far_rst_evt && (react_sel_q == REACT_PEER);
    sticky_clr  = rst || int_reset.fund;
  end

  mode_deadlock_arbiter #(
    .YIELD_ON_TIE (!IS_INTERNAL)
  ) u_arbiter (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .own_idle  (mode_q != MODE_ENABLED),
    .peer_idle (peer_mode != MODE_ENABLED),
    .yield     (yield)
  );

  // ---------------------------------------------------------------------------
  // Far-side mode field
  // ---------------------------------------------------------------------------
  // Forced stalls from a far reset outrank software so that a host cannot race the
  // reaction away; the deadlock fallback outranks everything but internal reset.
  always_ff @(posedge clk_sys) begin
    if (rst || int_reset.fund || int_reset.hot) begin
      mode_q <= IS_INTERNAL ? MODE_RST_INT : MODE_RST_EXT;
    end else if (yield) begin
      mode_q <= MODE_ENABLED;
    end else if (react_self || peer_force_not_ready) begin
      mode_q <= MODE_NOT_READY;
    end else if (wr_ctl && cfg_req.wdata[MODE_MSB:MODE_LSB] != MODE_RESERVED) begin
      mode_q <= cfg_req.wdata[MODE_MSB:MODE_LSB];
    end
  end

  // ---------------------------------------------------------------------------
  // Sticky control bits
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sticky_clr) begin
      guard_q     <= BIT_RST;
      propagate_q <= BIT_RST;
    end else if (wr_ctl) begin
      guard_q     <= cfg_req.wdata[GUARD_BIT];
      propagate_q <= cfg_req.wdata[PROPAGATE_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sticky_clr || !IS_INTERNAL) begin
      react_en_q  <= BIT_RST;
      react_sel_q <= BIT_RST;
    end else if (wr_ctl) begin
      react_en_q  <= cfg_req.wdata[REACT_EN_BIT];
      react_sel_q <= cfg_req.wdata[REACT_SEL_BIT];
    end
  end

  // ---------------------------------------------------------------------------
  // Status flag
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sticky_clr) begin
      fund_seen_q <= BIT_RST;
    end else if (far_reset.fund) begin
      fund_seen_q <= 1'b1;
    end else if (wr_sts && cfg_req.wdata[FUND_SEEN_BIT]) begin
      fund_seen_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Whole-chip reset request
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      chip_rst_q <= 1'b0;
    end else begin
      chip_rst_q <= (wr_ctl && cfg_req.wdata[CHIP_RST_BIT])
                 || (propagate_q && isolating_bridge && !bridge_port_reset_pin_n);
    end
  end

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------
  always_comb begin
    ctl_view = BYTE_ZERO;
    ctl_view[MODE_MSB:MODE_LSB] = mode_q;
    ctl_view[GUARD_BIT]         = guard_q;
    ctl_view[REACT_EN_BIT]      = react_en_q;
    ctl_view[REACT_SEL_BIT]     = react_sel_q;
    ctl_view[PROPAGATE_BIT]     = propagate_q;
    sts_view = BYTE_ZERO;
    sts_view[FUND_SEEN_BIT]     = fund_seen_q;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_rsp <= '0;
    end else begin
      cfg_rsp.valid <= cfg_req.valid;
      if (!cfg_req.valid || cfg_req.write || guarded) begin
        cfg_rsp.rdata <= BYTE_ZERO;
      end else if (cfg_req.addr == CTL_OFFSET) begin
        cfg_rsp.rdata <= ctl_view;
      end else if (cfg_req.addr == STS_OFFSET) begin
        cfg_rsp.rdata <= sts_view;
      end else begin
        cfg_rsp.rdata <= BYTE_ZERO;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Transaction steering
  // ---------------------------------------------------------------------------
  always_comb begin
    far_side_mode     = mode_q;
    chip_fund_reset   = chip_rst_q;
    far_credit_return = far_tlp_valid;
    near_to_far_allow = 1'b1;
    far_tlp_accept    = 1'b0;
    far_tlp_crs       = 1'b0;
    far_tlp_discard   = 1'b0;
    case (mode_q)
      MODE_NOT_READY: begin
        far_tlp_crs     = far_tlp_valid && far_tlp_is_cfg;
        far_tlp_discard = far_tlp_valid && !far_tlp_is_cfg;
      end
      MODE_DISABLED: begin
        far_tlp_discard = far_tlp_valid;
      end
      default: begin
        far_tlp_accept  = far_tlp_valid;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  sequence far_fund_s;
    far_reset.fund && !sticky_clr;
  endsequence
  sequence chip_wr_s;
    wr_ctl && cfg_req.wdata[CHIP_RST_BIT];
  endsequence

  mode_reset_val_a: assert property (@(posedge clk_sys) (rst || int_reset.hot) |=>
    mode_q == (IS_INTERNAL ? MODE_RST_INT : MODE_RST_EXT))
    else $error("mode not restored by reset");
  not_ready_crs_a: assert property (@(posedge clk_sys) disable iff (rst)
    (mode_q == MODE_NOT_READY && far_tlp_valid) |-> (far_tlp_crs == far_tlp_is_cfg) && !far_tlp_accept)
    else $error("not ready side did not retry config");
  disabled_drop_a: assert property (@(posedge clk_sys) disable iff (rst)
    (mode_q == MODE_DISABLED && far_tlp_valid) |-> far_tlp_discard && near_to_far_allow)
    else $error("disabled side did not discard");
  credit_return_a: assert property (@(posedge clk_sys) disable iff (rst)
    far_tlp_valid |-> far_credit_return)
    else $error("credits withheld");
  deadlock_break_a: assert property (@(posedge clk_sys) disable iff (rst)
    (yield && !int_reset.fund && !int_reset.hot) |=> mode_q == MODE_ENABLED)
    else $error("stall not broken");
  guard_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    (guarded && cfg_req.write && !yield && !react_self && !peer_force_not_ready
     && !int_reset.hot && !int_reset.fund)
    |=> $stable(mode_q) && $stable(guard_q))
    else $error("guarded write changed state");
  guard_read_a: assert property (@(posedge clk_sys) disable iff (rst)
    (guarded && !cfg_req.write) |=> cfg_rsp.valid && cfg_rsp.rdata == BYTE_ZERO)
    else $error("guarded read leaked data");
  ext_react_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
    !IS_INTERNAL |-> !react_en_q && !react_sel_q && !force_peer_not_ready)
    else $error("external side holds reaction bits");
  fund_seen_a: assert property (@(posedge clk_sys) disable iff (rst)
    far_fund_s |=> fund_seen_q)
    else $error("far fund reset not flagged");
  chip_reset_a: assert property (@(posedge clk_sys) disable iff (rst)
    chip_wr_s |=> chip_fund_reset ##1 (cfg_rsp.rdata[CHIP_RST_BIT] == 1'b0))
    else $error("chip reset not requested");
  propagate_a: assert property (@(posedge clk_sys) disable iff (rst)
    (propagate_q && isolating_bridge && !bridge_port_reset_pin_n) |=> chip_fund_reset)
    else $error("pin reset not propagated");
  react_self_a: assert property (@(posedge clk_sys) disable iff (rst)
    (react_self && !yield && !int_reset.fund && !int_reset.hot) |=> mode_q == MODE_NOT_READY)
    else $error("self reaction missing");
endmodule

// *** core/mode_deadlock_arbiter.sv ***
// Decides when this side must fall back to enabled to break a mutual stall.
`timescale 1ns/1ps
module mode_deadlock_arbiter
  import bridge_pkg::*;
#(
  parameter bit YIELD_ON_TIE = 1'b1
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic own_idle,
  input  wire logic peer_idle,
  output logic      yield
);
  logic own_idle_q;
  logic peer_idle_q;

  // ---------------------------------------------------------------------------
  // History of both sides
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      own_idle_q  <= 1'b0;
      peer_idle_q <= 1'b0;
    end else begin
      own_idle_q  <= own_idle;
      peer_idle_q <= peer_idle;
    end
  end

  // The side already stalled yields; a simultaneous entry is broken by parameter
  // so that exactly one of the two instances gives way.
  always_comb begin
    yield = own_idle && peer_idle && !peer_idle_q && (own_idle_q || YIELD_ON_TIE);
  end
endmodule

// *** dv/peer_side_model.sv ***
// Behavioural model of the opposite bridge side's mode register.
`timescale 1ns/1ps
module peer_side_model (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       set_en,
  input  wire logic [1:0] set_val,
  input  wire logic       force_nr,
  input  wire logic [1:0] other_mode,
  output logic [1:0]      mode_q
);
  logic other_busy_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      other_busy_q <= 1'b0;
    end else begin
      other_busy_q <= other_mode != 2'h0;
    end
  end
  // The peer that stalled first gives way, so a mutual stall never lasts.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode_q <= 2'h0;
    end else if (mode_q != 2'h0 && other_mode != 2'h0 && !other_busy_q) begin
      mode_q <= 2'h0;
    end else if (force_nr) begin
      mode_q <= 2'h1;
    end else if (set_en) begin
      mode_q <= set_val;
    end
  end
endmodule

// *** dv/tb_bridge_far_side_control.sv ***
// Self-checking bench for the far-side bridge control block, internal side.
`timescale 1ns/1ps
module tb_bridge_far_side_control
  import bridge_pkg::*;
;
  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  logic       clk_sys, rst, cap_write_block, cap_read_zero, blk, rz;
  cfg_req_t   cfg_req;
  cfg_rsp_t   cfg_rsp;
  cfg_rsp_t   ext_rsp;
  reset_evt_t int_reset, far_reset;
  logic       isolating_bridge, bridge_port_reset_pin_n, peer_force_not_ready;
  logic       force_peer_not_ready, far_tlp_valid, far_tlp_is_cfg, far_tlp_accept;
  logic       far_tlp_crs, far_tlp_discard, far_credit_return, near_to_far_allow;
  logic       chip_fund_reset, set_en;
  logic [1:0] peer_mode, far_side_mode, set_val;
  logic [7:0] rd;
  int         failures, checks;
  bridge_far_side_control i_dut (
    .clk_sys, .rst, .cfg_req, .cfg_rsp, .cap_write_block, .cap_read_zero,
    .int_reset, .far_reset, .isolating_bridge, .bridge_port_reset_pin_n,
    .peer_mode, .peer_force_not_ready, .force_peer_not_ready, .far_side_mode,
    .far_tlp_valid, .far_tlp_is_cfg, .far_tlp_accept, .far_tlp_crs,
    .far_tlp_discard, .far_credit_return, .near_to_far_allow, .chip_fund_reset
  );
  peer_side_model i_peer (
    .clk_sys, .rst, .set_en, .set_val, .force_nr(force_peer_not_ready),
    .other_mode(far_side_mode), .mode_q(peer_mode)
  );
  // The external side sees every access too, so its reaction bits can be read back.
  bridge_far_side_control #(.IS_INTERNAL(1'b0)) i_ext (
    .clk_sys, .rst, .cfg_req, .cfg_rsp(ext_rsp), .cap_write_block(), .cap_read_zero(),
    .int_reset, .far_reset, .isolating_bridge, .bridge_port_reset_pin_n,
    .peer_mode(2'h0), .peer_force_not_ready(1'b0), .force_peer_not_ready(),
    .far_side_mode(), .far_tlp_valid, .far_tlp_is_cfg, .far_tlp_accept(),
    .far_tlp_crs(), .far_tlp_discard(), .far_credit_return(), .near_to_far_allow(),
    .chip_fund_reset()
  );
  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // One byte access; the guard flags are only meaningful while the request stands.
  task automatic acc(input logic w, input logic f, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    cfg_req <= {1'b1, w, f, a, d};
    #1;
    blk = cap_write_block;
    rz = cap_read_zero;
    @(posedge clk_sys);
    cfg_req <= '0;
    #1;
    chk({7'h00, cfg_rsp.valid}, 8'h01);
    rd = cfg_rsp.rdata;
  endtask
  task automatic evt(input reset_evt_t fe, input reset_evt_t ie);
    @(posedge clk_sys);
    far_reset <= fe;
    int_reset <= ie;
    @(posedge clk_sys);
    far_reset <= '0;
    int_reset <= '0;
    #1;
  endtask
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset_status;
    acc(1'b0, 1'b0, CTL_OFFSET, 8'h00);
    chk(rd, 8'h01);
    evt(2'b10, 2'b00);
    chk({6'h00, far_side_mode}, 8'h01);
    acc(1'b0, 1'b0, STS_OFFSET, 8'h00);
    chk(rd, 8'h01);
    acc(1'b1, 1'b0, STS_OFFSET, 8'h01);
    acc(1'b0, 1'b0, STS_OFFSET, 8'h00);
    chk(rd, 8'h00);
    $display("test reset_status done");
  endtask
  task automatic t_modes;
    logic [1:0] m;
    for (int i = 0; i < 4; i++) begin
      m = (i == 3) ? MODE_DISABLED : i[1:0];
      acc(1'b1, 1'b0, CTL_OFFSET, {6'h00, i[1:0]});
      chk({6'h00, far_side_mode}, {6'h00, m});
      for (int c = 0; c < 2; c++) begin
        @(posedge clk_sys);
        far_tlp_valid <= 1'b1;
        far_tlp_is_cfg <= c[0];
        #1;
        chk({3'h0, far_tlp_accept, far_tlp_crs, far_tlp_discard, far_credit_return,
             near_to_far_allow}, {3'h0, m == 2'h0, m == 2'h1 && c[0],
             (m == 2'h1 && !c[0]) || m == 2'h2, 2'b11});
      end
      @(posedge clk_sys);
      far_tlp_valid <= 1'b0;
    end
    $display("test modes done");
  endtask
  task automatic t_deadlock;
    acc(1'b1, 1'b0, CTL_OFFSET, 8'h01);
    @(posedge clk_sys);
    set_en <= 1'b1;
    set_val <= MODE_DISABLED;
    @(posedge clk_sys);
    set_en <= 1'b0;
    tick(1);
    chk({4'h0, far_side_mode, peer_mode}, 8'h02);
    $display("test deadlock done");
  endtask
  task automatic t_react;
    acc(1'b1, 1'b0, CTL_OFFSET, 8'h08);
    evt(2'b01, 2'b00);
    chk({6'h00, peer_mode}, 8'h01);
    acc(1'b1, 1'b0, CTL_OFFSET, 8'h18);
    acc(1'b0, 1'b0, CTL_OFFSET, 8'h00);
    chk(rd, 8'h18);
    chk({6'h00, ext_rsp.rdata[4:3]}, 8'h00);
    evt(2'b01, 2'b00);
    chk({6'h00, far_side_mode}, 8'h01);
    tick(2);
    chk({4'h0, far_side_mode, peer_mode}, 8'h04);
    $display("test react done");
  endtask
  task automatic t_guard;
    acc(1'b1, 1'b0, CTL_OFFSET, 8'h04);
    acc(1'b1, 1'b1, CTL_OFFSET, 8'h02);
    chk({blk, 5'h00, far_side_mode}, 8'h80);
    acc(1'b0, 1'b1, CTL_OFFSET, 8'h00);
    chk({rz, rd[6:0]}, 8'h80);
    acc(1'b0, 1'b1, CAP_BASE, 8'h00);
    chk({7'h00, rz}, 8'h00);
    acc(1'b0, 1'b0, CTL_OFFSET, 8'h00);
    chk(rd, 8'h04);
    @(posedge clk_sys);
    peer_force_not_ready <= 1'b1;
    @(posedge clk_sys);
    peer_force_not_ready <= 1'b0;
    #1;
    chk({6'h00, far_side_mode}, 8'h01);
    $display("test guard done");
  endtask
  task automatic t_chip;
    acc(1'b1, 1'b0, CTL_OFFSET, 8'h84);
    chk({7'h00, chip_fund_reset}, 8'h01);
    acc(1'b0, 1'b0, CTL_OFFSET, 8'h00);
    chk(rd, 8'h04);
    acc(1'b1, 1'b0, CTL_OFFSET, 8'h24);
    for (int s = 0; s < 2; s++) begin
      @(posedge clk_sys);
      isolating_bridge <= s[0];
      bridge_port_reset_pin_n <= 1'b0;
      tick(1);
      chk({7'h00, chip_fund_reset}, {7'h00, s[0]});
    end
    @(posedge clk_sys);
    bridge_port_reset_pin_n <= 1'b1;
    $display("test chip done");
  endtask
  task automatic t_int_reset;
    evt(2'b00, 2'b01);
    acc(1'b0, 1'b0, CTL_OFFSET, 8'h00);
    chk(rd, 8'h25);
    evt(2'b00, 2'b10);
    acc(1'b0, 1'b0, CTL_OFFSET, 8'h00);
    chk(rd, 8'h01);
    $display("test int_reset done");
  endtask
  // ---------------------------------------------------------------------------
  // Clock and main sequence
  // ---------------------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    rst = 1'b1;
    cfg_req = '0;
    int_reset = '0;
    far_reset = '0;
    isolating_bridge = 1'b0;
    bridge_port_reset_pin_n = 1'b1;
    peer_force_not_ready = 1'b0;
    far_tlp_valid = 1'b0;
    far_tlp_is_cfg = 1'b0;
    set_en = 1'b0;
    set_val = 2'h0;
    failures = 0;
    checks = 0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset_status();
    t_modes();
    t_deadlock();
    t_react();
    t_guard();
    t_chip();
    t_int_reset();
    stop_test();
  end
endmodule

// *** inc/bridge_pkg.sv ***
// Shared constants and carrier types for the far-side bridge control block.
package bridge_pkg;
  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [11:0] CTL_OFFSET    = 12'h078;
  localparam logic [11:0] STS_OFFSET    = 12'h079;
  localparam logic [11:0] CAP_BASE      = 12'h074;
  localparam logic [11:0] CAP_HDR_LAST  = 12'h077;
  localparam logic [11:0] CAP_LENGTH    = 12'h040;
  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int MODE_LSB      = 0;
  localparam int MODE_MSB      = 1;
  localparam int GUARD_BIT     = 2;
  localparam int REACT_EN_BIT  = 3;
  localparam int REACT_SEL_BIT = 4;
  localparam int PROPAGATE_BIT = 5;
  localparam int CHIP_RST_BIT  = 7;
  localparam int FUND_SEEN_BIT = 0;
  // ---------------------------------------------------------------------------
  // Mode codes and reset values
  // ---------------------------------------------------------------------------
  localparam logic [1:0] MODE_ENABLED   = 2'h0;
  localparam logic [1:0] MODE_NOT_READY = 2'h1;
  localparam logic [1:0] MODE_DISABLED  = 2'h2;
  localparam logic [1:0] MODE_RESERVED  = 2'h3;
  localparam logic [1:0] MODE_RST_EXT   = MODE_ENABLED;
  localparam logic [1:0] MODE_RST_INT   = MODE_NOT_READY;
  localparam logic       BIT_RST        = 1'b0;
  localparam logic [7:0] BYTE_ZERO      = 8'h00;
  localparam logic       REACT_PEER     = 1'b0;
  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        from_far;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } cfg_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] rdata;
  } cfg_rsp_t;

  typedef struct packed {
    logic fund;
    logic hot;
  } reset_evt_t;
endpackage
